// >>> hdl/pae_chan.sv
// one alarm channel: comparison, hysteresis and standby sequence
`timescale 1ns/1ps
module pae_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // settings
  input wire logic [pae_pkg::TW-1:0] type_i,
  input wire logic signed [pae_pkg::VW-1:0] av_i,
  input wire logic [pae_pkg::VW-1:0] hyst_i,
  input wire logic restart_i,
  // process values
  input wire logic signed [pae_pkg::VW-1:0] pv_i,
  input wire logic signed [pae_pkg::VW-1:0] sp_i,
  // result
  output logic alarm_o,
  output logic armed_o
);
  localparam int EW = pae_pkg::VW + 2;
  typedef struct packed {
    logic inr;
    logic armed;
    logic alarm;
  } pae_chan_s;
  pae_chan_s q, d;
  logic signed [EW-1:0] dv, x, nx, lt, h;
  logic dev, sb, neg, hi_on, hi_off, lo_on, lo_off, in_on, in_off, on, off, f_on, f_off;

  always_comb begin
    dev = (type_i >= pae_pkg::T_UL_DEV) && (type_i <= pae_pkg::T_LO_SB);
    sb = type_i inside {pae_pkg::T_UL_SB, pae_pkg::T_UP_SB, pae_pkg::T_LO_SB,
                        pae_pkg::T_UP_ABS_SB, pae_pkg::T_LO_ABS_SB};
    neg = av_i[pae_pkg::VW-1];
    x = EW'(av_i);
    nx = -x;
    h = signed'(EW'(hyst_i));
    // deviation from set point or absolute value
    dv = dev ? EW'(pv_i) - EW'(sp_i) : EW'(pv_i);
    lt = dev ? nx : x;
    hi_on = dv > x;
    hi_off = dv <= x - h;
    lo_on = dv < lt;
    lo_off = dv >= lt + h;
    in_on = (dv <= x) && (dv >= nx);
    in_off = (dv > x + h) || (dv < nx - h);
    f_on = 1'b0;
    f_off = 1'b0;
    unique case (type_i)
      pae_pkg::T_UL_DEV, pae_pkg::T_UL_SB: begin
        on = hi_on || lo_on;
        off = hi_off && lo_off;
      end
      pae_pkg::T_UP_DEV, pae_pkg::T_UP_SB, pae_pkg::T_UP_ABS, pae_pkg::T_UP_ABS_SB: begin
        on = hi_on;
        off = hi_off;
      end
      pae_pkg::T_LO_DEV, pae_pkg::T_LO_SB, pae_pkg::T_LO_ABS, pae_pkg::T_LO_ABS_SB: begin
        on = lo_on;
        off = lo_off;
      end
      pae_pkg::T_RNG_DEV: begin
        on = in_on;
        off = in_off;
      end
      default: begin
        on = 1'b0;
        off = 1'b1;
        f_off = 1'b1;
      end
    endcase
    // type 1 negative value always on
    if (neg && type_i == pae_pkg::T_UL_DEV) begin
      f_on = 1'b1;
    end
    // types 4 and 5 negative value always off
    if (neg && (type_i == pae_pkg::T_RNG_DEV || type_i == pae_pkg::T_UL_SB)) begin
      f_off = 1'b1;
    end
    d = q;
    if (f_on) begin
      d.inr = 1'b1;
    end else if (f_off) begin
      d.inr = 1'b0;
    end else begin
      d.inr = q.inr ? !off : on;
    end
    // standby holds off until the range is left once
    if (!sb) begin
      d.armed = 1'b0;
    end else if (restart_i) begin
      d.armed = 1'b1;
    end else begin
      d.armed = q.armed && d.inr;
    end
    d.alarm = d.inr && !d.armed;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '{inr: 1'b0, armed: 1'b1, alarm: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign alarm_o = q.alarm;
  assign armed_o = q.armed;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  type1_neg_a: assert property (neg && type_i == pae_pkg::T_UL_DEV |=> alarm_o)
    else $error("type 1 with negative value not alarmed");
  neg_off_a: assert property (
    neg && (type_i == pae_pkg::T_RNG_DEV || type_i == pae_pkg::T_UL_SB) |=> !alarm_o)
    else $error("type 4 or 5 with negative value alarmed");
  sequence sb_restart;
    sb && restart_i && !f_on;
  endsequence
  sequence sb_hold_in;
    (sb && !restart_i && on && !off) [*2];
  endsequence
  standby_off_a: assert property (sb_restart ##1 sb_hold_in |-> !alarm_o)
    else $error("standby alarm raised without leaving range");
  abs_upper_a: assert property (
    type_i == pae_pkg::T_UP_ABS && $stable(type_i) && EW'(pv_i) > x |=> alarm_o)
    else $error("absolute upper alarm missed");
  bad_type_a: assert property (!(type_i inside {[pae_pkg::T_UL_DEV:pae_pkg::T_LO_ABS_SB]}) |=> !alarm_o)
    else $error("undefined type raised alarm");
endmodule

// >>> hdl/pae_pkg.sv
// constants and types for the process alarm evaluator
// Overview of operation
// - three independent alarm channels, one to three, each with its own on/off result
// - a channel drives its contact only when routed to an output
// - on/off decision comes from type code, alarm value and hysteresis together
// - contact state while alarm is active is selectable open or closed
// - type 1 is upper-and-lower deviation; negative alarm value keeps it always on
// - types 1-7 relative to set point, 8-11 absolute; 5,6,7,10,11 use standby
// - each channel holds its own type code, reset to 2, upper deviation
// - comparison follows the alarm value sign; types 4 and 5 negative mean always off
// - alarm values stored per pattern; running pattern's values are compared
// - heating control period resets to 20 seconds
// - per-channel hysteresis, default 0.02 percent of full scale, on switching
// - open-in-alarm inverts the output; close-in-alarm, the default, passes it
// - standby types stay off until value leaves the alarm range then re-enters
package pae_pkg;
  localparam int NCH = 3;
  localparam int NPAT = 8;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int VW = 16;
  localparam int TW = 4;
  localparam int PW = 3;
  localparam int CW = 8;
  localparam int HW = 25;
  // register byte addresses
  localparam logic [AW-1:0] AD_CTRL = 8'h00;
  localparam logic [AW-1:0] AD_TYPE0 = 8'h04;
  localparam logic [AW-1:0] AD_HYST0 = 8'h10;
  localparam logic [AW-1:0] AD_CP = 8'h20;
  localparam logic [AW-1:0] AD_MENU = 8'h24;
  localparam logic [AW-1:0] AD_STAT = 8'h28;
  localparam logic [AW-1:0] REG_STEP = 8'h04;
  // alarm value table: bit 7 set, pattern in [6:4], channel in [3:2]
  localparam int AV_SEL_BIT = 7;
  localparam int AV_PAT_LSB = 4;
  localparam int AV_CH_LSB = 2;
  localparam int AV_CH_W = 2;
  // field positions
  localparam int CTRL_ROUTE_LSB = 0;
  localparam int CTRL_OPEN_LSB = 4;
  localparam int ST_ALM_LSB = 0;
  localparam int ST_SB_LSB = 4;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_PAT_LSB = 12;
  localparam int MENU_W = 2;
  // alarm type codes
  localparam logic [TW-1:0] T_UL_DEV = 4'h1;
  localparam logic [TW-1:0] T_UP_DEV = 4'h2;
  localparam logic [TW-1:0] T_LO_DEV = 4'h3;
  localparam logic [TW-1:0] T_RNG_DEV = 4'h4;
  localparam logic [TW-1:0] T_UL_SB = 4'h5;
  localparam logic [TW-1:0] T_UP_SB = 4'h6;
  localparam logic [TW-1:0] T_LO_SB = 4'h7;
  localparam logic [TW-1:0] T_UP_ABS = 4'h8;
  localparam logic [TW-1:0] T_LO_ABS = 4'h9;
  localparam logic [TW-1:0] T_UP_ABS_SB = 4'ha;
  localparam logic [TW-1:0] T_LO_ABS_SB = 4'hb;
  // reset values
  localparam logic [TW-1:0] TYPE_RST = T_UP_DEV;
  localparam logic [VW-1:0] HYST_RST = 16'h0002;
  localparam logic [VW-1:0] AV_RST = 16'h0000;
  localparam int CP_HEAT_S = 32'h0000_0014;
  localparam logic [CW-1:0] CP_RST = CW'(CP_HEAT_S);
  localparam logic [NCH-1:0] ROUTE_RST = 3'h7;
  localparam logic [NCH-1:0] OPEN_RST = 3'h0;
  // timing
  localparam int CLK_HZ = 32'h0131_2d00;
  localparam int KEY_HOLD_MS = 32'h0000_03e8;
  localparam int MS_PER_S = 32'h0000_03e8;
  localparam int KEY_HOLD_CYC = (CLK_HZ / MS_PER_S) * KEY_HOLD_MS;
  typedef enum logic [1:0] {MODE_MENU, MODE_SETUP, MODE_LVL1} pae_mode_e;
endpackage

// >>> hdl/pae_top.sv
// process alarm evaluator: registers, channel array, contacts and key hold
`timescale 1ns/1ps
module pae_top #(
  parameter int unsigned KEY_HOLD_CYC = pae_pkg::KEY_HOLD_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [pae_pkg::AW-1:0] addr_i,
  input wire logic [pae_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pae_pkg::DW-1:0] rdata_o,
  // process side
  input wire logic signed [pae_pkg::VW-1:0] pv_i,
  input wire logic signed [pae_pkg::VW-1:0] sp_i,
  input wire logic [pae_pkg::PW-1:0] pattern_i,
  input wire logic restart_i,
  // operator key pin
  input wire logic mode_key_i,
  // outputs
  output logic [pae_pkg::NCH-1:0] contact_o,
  output logic [1:0] mode_o,
  output logic [pae_pkg::CW-1:0] cp_heat_o
);
  localparam int NCH = pae_pkg::NCH;
  localparam int VW = pae_pkg::VW;
  localparam logic [pae_pkg::HW-1:0] HOLD_LAST = pae_pkg::HW'(KEY_HOLD_CYC - 1);

  typedef struct packed {
    logic [NCH-1:0] route;
    logic [NCH-1:0] openp;
    logic [NCH-1:0][pae_pkg::TW-1:0] typ;
    logic [NCH-1:0][VW-1:0] hyst;
    logic [pae_pkg::CW-1:0] cp;
    logic [pae_pkg::NPAT-1:0][NCH-1:0][VW-1:0] av;
    pae_pkg::pae_mode_e target;
    pae_pkg::pae_mode_e mode;
    logic [pae_pkg::HW-1:0] hold;
    logic key_s1;
    logic key_s2;
    logic [pae_pkg::PW-1:0] pat;
    logic restart;
    logic [NCH-1:0] contact;
    logic [pae_pkg::DW-1:0] rdata;
  } pae_top_s;

  pae_top_s q, d;
  logic [NCH-1:0] alm;
  logic [NCH-1:0] armed;
  logic av_hit;
  logic [pae_pkg::PW-1:0] av_pat;
  logic [pae_pkg::AV_CH_W-1:0] av_ch;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    pae_chan u_chan (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .type_i(q.typ[g]),
      .av_i(signed'(q.av[q.pat][g])),
      .hyst_i(q.hyst[g]),
      .restart_i(q.restart),
      .pv_i(pv_i),
      .sp_i(sp_i),
      .alarm_o(alm[g]),
      .armed_o(armed[g])
    );
  end

  always_comb begin
    d = q;
    av_hit = addr_i[pae_pkg::AV_SEL_BIT] &&
             (addr_i[pae_pkg::AV_CH_LSB +: pae_pkg::AV_CH_W] < pae_pkg::AV_CH_W'(NCH));
    av_pat = addr_i[pae_pkg::AV_PAT_LSB +: pae_pkg::PW];
    av_ch = addr_i[pae_pkg::AV_CH_LSB +: pae_pkg::AV_CH_W];
    d.restart = restart_i;
    // running pattern follows the program stepper; a change restarts standby
    d.pat = pattern_i;
    if (pattern_i != q.pat) begin
      d.restart = 1'b1;
    end
    // register writes
    if (wr_i) begin
      if (addr_i == pae_pkg::AD_CTRL) begin
        d.route = wdata_i[pae_pkg::CTRL_ROUTE_LSB +: NCH];
        d.openp = wdata_i[pae_pkg::CTRL_OPEN_LSB +: NCH];
      end
      for (int i = 0; i < NCH; i++) begin
        if (addr_i == pae_pkg::AD_TYPE0 + pae_pkg::AW'(i) * pae_pkg::REG_STEP) begin
          d.typ[i] = wdata_i[pae_pkg::TW-1:0];
          d.restart = 1'b1;
        end
        if (addr_i == pae_pkg::AD_HYST0 + pae_pkg::AW'(i) * pae_pkg::REG_STEP) begin
          d.hyst[i] = wdata_i[VW-1:0];
        end
      end
      if (addr_i == pae_pkg::AD_CP) begin
        d.cp = wdata_i[pae_pkg::CW-1:0];
      end
      if (addr_i == pae_pkg::AD_MENU) begin
        d.target = pae_pkg::pae_mode_e'(wdata_i[pae_pkg::MENU_W-1:0]);
        d.mode = pae_pkg::MODE_MENU;
      end
      if (av_hit) begin
        d.av[av_pat][av_ch] = wdata_i[VW-1:0];
        if (av_pat == q.pat) begin
          d.restart = 1'b1;
        end
      end
    end
    // register reads, data valid the cycle after the strobe only
    d.rdata = '0;
    if (rd_i) begin
      if (addr_i == pae_pkg::AD_CTRL) begin
        d.rdata[pae_pkg::CTRL_ROUTE_LSB +: NCH] = q.route;
        d.rdata[pae_pkg::CTRL_OPEN_LSB +: NCH] = q.openp;
      end
      for (int i = 0; i < NCH; i++) begin
        if (addr_i == pae_pkg::AD_TYPE0 + pae_pkg::AW'(i) * pae_pkg::REG_STEP) begin
          d.rdata[pae_pkg::TW-1:0] = q.typ[i];
        end
        if (addr_i == pae_pkg::AD_HYST0 + pae_pkg::AW'(i) * pae_pkg::REG_STEP) begin
          d.rdata[VW-1:0] = q.hyst[i];
        end
      end
      if (addr_i == pae_pkg::AD_CP) begin
        d.rdata[pae_pkg::CW-1:0] = q.cp;
      end
      if (addr_i == pae_pkg::AD_MENU) begin
        d.rdata[pae_pkg::MENU_W-1:0] = q.target;
      end
      if (addr_i == pae_pkg::AD_STAT) begin
        d.rdata[pae_pkg::ST_ALM_LSB +: NCH] = alm;
        d.rdata[pae_pkg::ST_SB_LSB +: NCH] = armed;
        d.rdata[pae_pkg::ST_MODE_LSB +: pae_pkg::MENU_W] = q.mode;
        d.rdata[pae_pkg::ST_PAT_LSB +: pae_pkg::PW] = q.pat;
      end
      if (av_hit) begin
        d.rdata[VW-1:0] = q.av[av_pat][av_ch];
      end
    end
    // key pin synchroniser
    d.key_s1 = mode_key_i;
    d.key_s2 = q.key_s1;
    // key held one second enters the selected mode
    d.hold = '0;
    if (q.mode == pae_pkg::MODE_MENU && q.key_s2 &&
        (q.target == pae_pkg::MODE_SETUP || q.target == pae_pkg::MODE_LVL1) &&
        !(wr_i && addr_i == pae_pkg::AD_MENU)) begin
      if (q.hold == HOLD_LAST) begin
        d.mode = q.target;
      end else begin
        d.hold = q.hold + 1'b1;
      end
    end
    d.contact = q.route & (alm ^ q.openp);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q.route <= pae_pkg::ROUTE_RST;
      q.openp <= pae_pkg::OPEN_RST;
      q.typ <= {NCH{pae_pkg::TYPE_RST}};
      q.hyst <= {NCH{pae_pkg::HYST_RST}};
      q.cp <= pae_pkg::CP_RST;
      q.av <= {(pae_pkg::NPAT * NCH){pae_pkg::AV_RST}};
      q.target <= pae_pkg::MODE_MENU;
      q.mode <= pae_pkg::MODE_MENU;
      q.hold <= '0;
      q.key_s1 <= 1'b0;
      q.key_s2 <= 1'b0;
      q.pat <= '0;
      q.restart <= 1'b1;
      q.contact <= '0;
      q.rdata <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign contact_o = q.contact;
  assign mode_o = q.mode;
  assign cp_heat_o = q.cp;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  unrouted_off_a: assert property (!q.route[0] && $stable(q.route) |=> !contact_o[0])
    else $error("unrouted channel drives contact");
  open_invert_a: assert property (q.route[1] && q.openp[1] |=> contact_o[1] == !$past(alm[1]))
    else $error("open-in-alarm contact not inverted");
  close_pass_a: assert property (q.route[2] && !q.openp[2] |=> contact_o[2] == $past(alm[2]))
    else $error("close-in-alarm contact not passed through");
  key_hold_a: assert property (
    $changed(mode_o) && mode_o != pae_pkg::MODE_MENU |-> $past(q.hold) == HOLD_LAST && $past(q.key_s2))
    else $error("mode entered without full key hold");
  cp_write_a: assert property ($changed(cp_heat_o) |-> $past(wr_i) && $past(addr_i) == pae_pkg::AD_CP)
    else $error("control period changed without write");
  pat_restart_a: assert property (pattern_i != q.pat |=> q.restart ##1 (!$changed(q.pat) || q.restart))
    else $error("pattern change did not restart standby");
  type_store_a: assert property (
    wr_i && addr_i == pae_pkg::AD_TYPE0 |=> q.typ[0] == $past(wdata_i[pae_pkg::TW-1:0]))
    else $error("type code not stored");
endmodule

// >>> testbench/pae_keypad.sv
// operator keypad model driving the mode key pin
`timescale 1ns/1ps
module pae_keypad (
  // clock
  input wire logic clk_i,
  // key pin, high while pressed
  output logic key_o
);
  initial key_o = 1'b0;
  task automatic press(input int n);
    @(posedge clk_i);
    key_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    key_o <= 1'b0;
  endtask
endmodule

// >>> testbench/pae_top_bench.sv
// self-checking bench for the process alarm evaluator
`timescale 1ns/1ps
module pae_top_bench;
  localparam int HOLD = 8;
  logic clk_i, reset_n_i, wr_i, rd_i, restart_i, mode_key_i;
  logic [pae_pkg::AW-1:0] addr_i;
  logic [pae_pkg::DW-1:0] wdata_i, rdata_o;
  logic signed [pae_pkg::VW-1:0] pv_i, sp_i;
  logic [pae_pkg::PW-1:0] pattern_i;
  logic [pae_pkg::NCH-1:0] contact_o;
  logic [1:0] mode_o;
  logic [pae_pkg::CW-1:0] cp_heat_o;
  int bad_count = 0;
  int checks = 0;
  logic [3:0] tys [6] = '{pae_pkg::T_UL_DEV, pae_pkg::T_UP_DEV, pae_pkg::T_LO_DEV,
                         pae_pkg::T_RNG_DEV, pae_pkg::T_UP_ABS, pae_pkg::T_LO_ABS};

  pae_top #(.KEY_HOLD_CYC(HOLD)) pae_top_inst (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pv_i, .sp_i, .pattern_i, .restart_i, .mode_key_i, .contact_o, .mode_o, .cp_heat_o);
  pae_keypad pae_keypad_inst (.clk_i(clk_i), .key_o(mode_key_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic drive(input int pv, input int sp);
    @(posedge clk_i);
    pv_i <= 16'(pv);
    sp_i <= 16'(sp);
    settle();
  endtask

  function automatic logic exp_alarm(input logic [3:0] t, input int x, input int pv, input int sp);
    int d;
    d = (t >= pae_pkg::T_UP_ABS) ? pv : pv - sp;
    case (t)
      pae_pkg::T_UL_DEV: return (x < 0) || d > x || d < -x;
      pae_pkg::T_UP_DEV, pae_pkg::T_UP_ABS: return d > x;
      pae_pkg::T_LO_DEV: return d < -x;
      pae_pkg::T_LO_ABS: return d < x;
      pae_pkg::T_RNG_DEV: return x >= 0 && d >= -x && d <= x;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [31:0] v;
    logic [3:0] tv [3];
    int xv [3];
    int pv, sp;
    reset_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    pv_i = '0;
    sp_i = '0;
    pattern_i = '0;
    restart_i = 1'b0;
    void'($urandom(32'h03ea));
    repeat (15) @(posedge clk_i);
    #1;
    check("contact", contact_o, 32'h0);
    check("mode", mode_o, 32'h0);
    check("heat period", cp_heat_o, 32'h14);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      rd(pae_pkg::AD_TYPE0 + 8'(c * 4), v);
      check("type", v, 32'h2);
      rd(pae_pkg::AD_HYST0 + 8'(c * 4), v);
      check("hyst", v, 32'h2);
    end
    rd(pae_pkg::AD_CTRL, v);
    check("ctrl", v, 32'h7);
    rd(8'h30, v);
    check("unmapped", v, 32'h0);
    wr(pae_pkg::AD_CP, 32'h5);
    settle();
    check("heat period", cp_heat_o, 32'h5);
    // upper deviation with default hysteresis
    wr(8'h80, 32'ha);
    drive(61, 50);
    check("contact0", contact_o[0], 1'b1);
    drive(59, 50);
    check("contact0", contact_o[0], 1'b1);
    drive(58, 50);
    check("contact0", contact_o[0], 1'b0);
    for (int c = 0; c < 3; c++) wr(pae_pkg::AD_HYST0 + 8'(c * 4), 32'h0);
    // random types and values per channel, negative corners first
    for (int n = 0; n < 40; n++) begin
      for (int c = 0; c < 3; c++) begin
        tv[c] = tys[$urandom_range(5)];
        xv[c] = int'($urandom_range(200)) - 100;
        if (n == 0) begin
          tv[c] = (c == 1) ? pae_pkg::T_UL_DEV : pae_pkg::T_RNG_DEV;
          xv[c] = -7;
        end
        wr(pae_pkg::AD_TYPE0 + 8'(c * 4), 32'(tv[c]));
        wr(8'h80 + 8'(c * 4), 32'(16'(xv[c])));
      end
      pv = int'($urandom_range(400)) - 200;
      sp = int'($urandom_range(400)) - 200;
      drive(pv, sp);
      for (int c = 0; c < 3; c++) begin
        check("contact", contact_o[c], exp_alarm(tv[c], xv[c], pv, sp));
      end
    end
    // running pattern selects the alarm value
    wr(pae_pkg::AD_TYPE0, 32'(pae_pkg::T_UP_DEV));
    wr(8'h80, 32'ha);
    wr(8'h90, 32'h1e);
    drive(70, 50);
    check("contact0", contact_o[0], 1'b1);
    @(posedge clk_i);
    pattern_i <= 3'h1;
    settle();
    check("contact0", contact_o[0], 1'b0);
    // lower deviation with standby sequence
    drive(30, 50);
    wr(8'h90, 32'ha);
    wr(pae_pkg::AD_TYPE0, 32'(pae_pkg::T_LO_SB));
    settle();
    check("contact0", contact_o[0], 1'b0);
    drive(60, 50);
    check("contact0", contact_o[0], 1'b0);
    drive(30, 50);
    check("contact0", contact_o[0], 1'b1);
    @(posedge clk_i);
    restart_i <= 1'b1;
    @(posedge clk_i);
    restart_i <= 1'b0;
    settle();
    check("contact0", contact_o[0], 1'b0);
    drive(60, 50);
    drive(30, 50);
    check("contact0", contact_o[0], 1'b1);
    // polarity and routing, channels one and two open in alarm
    wr(pae_pkg::AD_CTRL, 32'h37);
    settle();
    check("contact0", contact_o[0], 1'b0);
    check("contact1", contact_o[1], !exp_alarm(tv[1], 0, 30, 50));
    drive(60, 50);
    check("contact0", contact_o[0], 1'b1);
    check("contact1", contact_o[1], !exp_alarm(tv[1], 0, 60, 50));
    wr(pae_pkg::AD_CTRL, 32'h36);
    settle();
    check("contact0", contact_o[0], 1'b0);
    // key hold into setup then level-1 mode
    for (int m = 1; m < 3; m++) begin
      wr(pae_pkg::AD_MENU, 32'(m));
      settle();
      check("mode", mode_o, 32'h0);
      pae_keypad_inst.press(HOLD / 2);
      settle();
      check("mode", mode_o, 32'h0);
      pae_keypad_inst.press(HOLD * 3);
      settle();
      check("mode", mode_o, 32'(m));
    end
    // status, menu target and alarm value read back
    rd(pae_pkg::AD_STAT, v);
    check("status mode", v[9:8], 32'h2);
    check("status pattern", v[14:12], 32'h1);
    @(posedge clk_i);
    #1;
    check("rdata idle", rdata_o, 32'h0);
    rd(pae_pkg::AD_MENU, v);
    check("menu", v, 32'h2);
    rd(8'h90, v);
    check("alarm value", v, 32'ha);
    // upper deviation with standby, then an undefined code, on channel three
    wr(8'h98, 32'h5);
    wr(pae_pkg::AD_TYPE0 + 8'h08, 32'(pae_pkg::T_UP_SB));
    settle();
    check("contact2", contact_o[2], 1'b0);
    drive(50, 50);
    drive(60, 50);
    check("contact2", contact_o[2], 1'b1);
    wr(pae_pkg::AD_TYPE0 + 8'h08, 32'hc);
    settle();
    check("contact2", contact_o[2], 1'b0);
    print_verdict();
  end
endmodule
